// ---- logic/phy_autoneg_regs.sv ----
// Contract
// - Partner ability register loads the link partner's advertised abilities; read only.
// - Bit 5.15 shows partner next page available; resets to zero.
// - Acknowledge bit 5.14 comes from received bursts; software never writes it.
// - Bit 5.13 shows partner remote fault; resets to zero.
// - Reserved bits 5.12-5.11 and 6.15-6.5 read zero; writes ignored.
// - Bit 5.10 shows partner pause capability; resets to zero.
// - Bits 5.9-5.5 show partner technologies, one per bit; reset zero.
// - Bits 5.4-5.0 hold partner selector code; reset all zeros.
// - Bit 6.4 latches high on parallel detection fault; resets zero.
// - Latched bits 6.4 and 6.1 stay set until register 6 read or device reset; 6.0 until restart or device reset.
// - Bit 6.3 shows partner next page able; resets zero.
// - Bit 6.2 local next page ability always reads zero.
// - Bit 6.1 sets on new page received, clears on register 6 read.
// - Bit 6.0 shows partner supports auto-negotiation; resets zero.
// - Bit 16.15 bypasses block coding both directions; resets zero.
// - Bit 16.14 bypasses scrambler and descrambler; resets zero.
// - Bit 16.13 bypasses alignment and scrambling paths; resets zero.
// - Bit 16.12 forces signal detect active; resets zero.
// - Bit 16.11 captures repeater strap at reset, writable; one means repeater.
// - Bit 16.10 selects twisted pair when one, fibre when zero; resets one.
// - Bit 16.9 enables far end fault for fibre; resets zero.
module phy_autoneg_regs
  import phy_regs_pkg::*;
#(
  parameter int unsigned DATA_W = 16,
  parameter int unsigned MGMT_ADDR_W = 5
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Management register port
  input wire logic [phy_regs_pkg::ADDR_W-1:0] mgmt_addr_i,
  input wire logic mgmt_wr_i,
  input wire logic mgmt_rd_i,
  input wire logic [phy_regs_pkg::REG_W-1:0] mgmt_wdata_i,
  output logic [phy_regs_pkg::REG_W-1:0] mgmt_rdata_o,
  output logic mgmt_rvalid_o,
  // Negotiation engine events
  input wire logic page_valid_i,
  input wire logic [phy_regs_pkg::REG_W-1:0] page_word_i,
  input wire logic page_ack_i,
  input wire logic pd_fault_i,
  input wire logic an_restart_i,
  // Straps and medium status
  input wire logic repeater_strap_i,
  input wire logic signal_detect_i,
  // Datapath controls
  output logic coding_bypass_o,
  output logic scrambler_bypass_o,
  output logic alignment_bypass_o,
  output logic signal_detect_o,
  output logic repeater_mode_o,
  output logic tx_mode_o,
  output logic far_end_fault_enable_o
);
  import phy_regs_pkg::*;

  if (DATA_W != REG_W) begin : g_bad_width
    $error("phy_autoneg_regs: DATA_W must equal 16");
  end
  if (MGMT_ADDR_W != ADDR_W) begin : g_bad_addr
    $error("phy_autoneg_regs: MGMT_ADDR_W must equal 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  wire logic hit_partner = addr_hit(mgmt_addr_i, PARTNER_ABILITY_OFS);
  wire logic hit_expansion = addr_hit(mgmt_addr_i, AUTONEG_EXPANSION_OFS);
  wire logic hit_config = addr_hit(mgmt_addr_i, VENDOR_CONFIGURATION_OFS);
  // Partner and expansion have no write path at all
  wire logic cfg_write = mgmt_wr_i & hit_config;
  wire logic exp_read = mgmt_rd_i & hit_expansion;

  ////////////////////////////////////////////////////////////////////////////
  // Captured negotiation status
  status_if st_bus ();

  assign st_bus.exp_read = exp_read;

  status_capture u_capture (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .page_valid_i(page_valid_i),
    .page_word_i(page_word_i),
    .page_ack_i(page_ack_i),
    .pd_fault_i(pd_fault_i),
    .an_restart_i(an_restart_i),
    .st(st_bus.capture)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Vendor configuration; low nine bits are not implemented here
  logic [REG_W-1:0] cfg_q;
  wire logic [REG_W-1:0] cfg_d = cfg_write ? (mgmt_wdata_i & CFG_IMPL_MASK) : cfg_q;
  wire logic [REG_W-1:0] cfg_rst_val = CFG_RST | (REG_W'(repeater_strap_i) << CF_REPEATER_BIT);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_q <= cfg_rst_val;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one-cycle latency, unmapped offsets read zero
  wire logic [REG_W-1:0] rd_mux =
      hit_partner ? st_bus.partner_word :
      hit_expansion ? st_bus.expansion_word :
      hit_config ? cfg_q : 16'h0000;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mgmt_rdata_o <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      mgmt_rdata_o <= mgmt_rd_i ? rd_mux : mgmt_rdata_o;
      mgmt_rvalid_o <= mgmt_rd_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath controls, registered so they follow the register one cycle late
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      coding_bypass_o <= 1'b0;
      scrambler_bypass_o <= 1'b0;
      alignment_bypass_o <= 1'b0;
      signal_detect_o <= 1'b0;
      repeater_mode_o <= 1'b0;
      tx_mode_o <= 1'b1;
      far_end_fault_enable_o <= 1'b0;
    end else begin
      coding_bypass_o <= cfg_q[CF_CODING_BYPASS_BIT];
      // Alignment bypass also skips scrambling
      scrambler_bypass_o <= cfg_q[CF_SCRAMBLER_BYPASS_BIT] | cfg_q[CF_ALIGNMENT_BYPASS_BIT];
      alignment_bypass_o <= cfg_q[CF_ALIGNMENT_BYPASS_BIT];
      signal_detect_o <= signal_detect_i | cfg_q[CF_FORCE_SD_BIT];
      repeater_mode_o <= cfg_q[CF_REPEATER_BIT];
      tx_mode_o <= cfg_q[CF_TX_MODE_BIT];
      far_end_fault_enable_o <= cfg_q[CF_FEF_BIT];
    end
  end

endmodule // phy_autoneg_regs

// ---- logic/phy_regs_pkg.sv ----
package phy_regs_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the management port
  localparam logic [4:0] PARTNER_ABILITY_OFS = 5'h05;
  localparam logic [4:0] AUTONEG_EXPANSION_OFS = 5'h06;
  localparam logic [4:0] VENDOR_CONFIGURATION_OFS = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Partner ability field positions
  localparam int unsigned PA_NEXT_PAGE_BIT = 15;
  localparam int unsigned PA_ACK_BIT = 14;
  localparam int unsigned PA_REMOTE_FAULT_BIT = 13;
  localparam int unsigned PA_RSVD_HI = 12;
  localparam int unsigned PA_RSVD_LO = 11;
  localparam int unsigned PA_PAUSE_BIT = 10;
  localparam int unsigned PA_TECH_HI = 9;
  localparam int unsigned PA_TECH_LO = 5;
  localparam int unsigned PA_SEL_HI = 4;
  localparam int unsigned PA_SEL_LO = 0;
  localparam logic [15:0] PARTNER_ABILITY_RST = 16'h0000;
  localparam logic [15:0] PARTNER_RSVD_MASK = 16'h1800;

  ////////////////////////////////////////////////////////////////////////////
  // Expansion field positions
  localparam int unsigned EX_PD_FAULT_BIT = 4;
  localparam int unsigned EX_PARTNER_PAGES_BIT = 3;
  localparam int unsigned EX_LOCAL_PAGES_BIT = 2;
  localparam int unsigned EX_PAGE_RX_BIT = 1;
  localparam int unsigned EX_PARTNER_AN_BIT = 0;
  localparam logic LOCAL_EXTRA_PAGES_CAPABLE = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Vendor configuration field positions and reset values
  localparam int unsigned CF_CODING_BYPASS_BIT = 15;
  localparam int unsigned CF_SCRAMBLER_BYPASS_BIT = 14;
  localparam int unsigned CF_ALIGNMENT_BYPASS_BIT = 13;
  localparam int unsigned CF_FORCE_SD_BIT = 12;
  localparam int unsigned CF_REPEATER_BIT = 11;
  localparam int unsigned CF_TX_MODE_BIT = 10;
  localparam int unsigned CF_FEF_BIT = 9;
  localparam logic [15:0] CFG_IMPL_MASK = 16'hFE00;
  localparam logic [15:0] CFG_RST = 16'h0400;

endpackage : phy_regs_pkg

// ---- logic/status_if.sv ----
interface status_if;
  import phy_regs_pkg::*;

  logic exp_read;
  logic [REG_W-1:0] partner_word;
  logic [REG_W-1:0] expansion_word;

  modport capture (
    input exp_read,
    output partner_word,
    output expansion_word
  );

  modport bank (
    output exp_read,
    input partner_word,
    input expansion_word
  );
endinterface : status_if

// ---- logic/status_capture.sv ----
module status_capture
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Negotiation engine events
  input wire logic page_valid_i,
  input wire logic [REG_W-1:0] page_word_i,
  input wire logic page_ack_i,
  input wire logic pd_fault_i,
  input wire logic an_restart_i,
  // Toward the register bank
  status_if.capture st
);

  logic [REG_W-1:0] partner_q;
  logic [REG_W-1:0] partner_d;
  logic pd_fault_q;
  logic pd_fault_d;
  logic page_rx_q;
  logic page_rx_d;
  logic an_able_q;
  logic an_able_d;

  ////////////////////////////////////////////////////////////////////////////
  // Partner word: reserved bits forced low, ack tracks the FLP engine
  wire logic [REG_W-1:0] page_clean = page_word_i & ~PARTNER_RSVD_MASK;

  always_comb begin
    partner_d = partner_q;
    if (an_restart_i) begin
      partner_d = PARTNER_ABILITY_RST;
    end else if (page_valid_i) begin
      partner_d = page_clean;
    end
    if (page_ack_i) begin
      partner_d[PA_ACK_BIT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latching flags: a set in the read-clear cycle wins; on an_able_q a restart beats a set
  assign pd_fault_d = (pd_fault_q & ~st.exp_read) | pd_fault_i;
  assign page_rx_d = (page_rx_q & ~st.exp_read) | page_valid_i;
  assign an_able_d = an_restart_i ? 1'b0 : (an_able_q | page_valid_i);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      partner_q <= PARTNER_ABILITY_RST;
      pd_fault_q <= 1'b0;
      page_rx_q <= 1'b0;
      an_able_q <= 1'b0;
    end else begin
      partner_q <= partner_d;
      pd_fault_q <= pd_fault_d;
      page_rx_q <= page_rx_d;
      an_able_q <= an_able_d;
    end
  end

  assign st.partner_word = partner_q;
  assign st.expansion_word = {11'h000, pd_fault_q,
                              partner_q[PA_NEXT_PAGE_BIT],
                              LOCAL_EXTRA_PAGES_CAPABLE,
                              page_rx_q, an_able_q};

endmodule // status_capture

// ---- verif/phy_regs_monitor.sv ----
module phy_regs_monitor
  import phy_regs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Observed port
  input wire logic [phy_regs_pkg::ADDR_W-1:0] mgmt_addr_i,
  input wire logic mgmt_rd_i,
  input wire logic [phy_regs_pkg::REG_W-1:0] mgmt_rdata_o,
  input wire logic mgmt_rvalid_o,
  input wire logic page_valid_i,
  input wire logic pd_fault_i,
  input wire logic an_restart_i,
  input wire logic scrambler_bypass_o,
  input wire logic alignment_bypass_o,
  input wire logic tx_mode_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_rvalid; mgmt_rd_i |=> mgmt_rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_no_rvalid; !mgmt_rd_i |=> !mgmt_rvalid_o; endproperty
  a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
  // Reset itself clears the read data, so the cycle after it is exempt
  property p_rdata_hold; !mgmt_rvalid_o && !$past(rst_i) |-> $stable(mgmt_rdata_o); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_rsvd5;
    mgmt_rvalid_o && $past(mgmt_addr_i) == PARTNER_ABILITY_OFS |-> (mgmt_rdata_o & PARTNER_RSVD_MASK) == 16'h0000;
  endproperty
  a_rsvd5: assert property (p_rsvd5) else $error("partner reserved bits set");
  property p_rsvd6;
    mgmt_rvalid_o && $past(mgmt_addr_i) == AUTONEG_EXPANSION_OFS |-> mgmt_rdata_o[15:5] == 11'h000;
  endproperty
  a_rsvd6: assert property (p_rsvd6) else $error("expansion reserved bits set");
  property p_local_np; mgmt_rvalid_o && $past(mgmt_addr_i) == AUTONEG_EXPANSION_OFS |-> !mgmt_rdata_o[2]; endproperty
  a_local_np: assert property (p_local_np) else $error("local page ability set");
  property p_page_rx;
    page_valid_i && !an_restart_i ##1 !an_restart_i && !(mgmt_rd_i && mgmt_addr_i == AUTONEG_EXPANSION_OFS)
      ##1 (mgmt_rd_i && mgmt_addr_i == AUTONEG_EXPANSION_OFS) |=> mgmt_rdata_o[1:0] == 2'h3;
  endproperty
  a_page_rx: assert property (p_page_rx) else $error("page flags missing");
  property p_pd_fault;
    pd_fault_i ##1 !(mgmt_rd_i && mgmt_addr_i == AUTONEG_EXPANSION_OFS)
      ##1 (mgmt_rd_i && mgmt_addr_i == AUTONEG_EXPANSION_OFS) |=> mgmt_rdata_o[4];
  endproperty
  a_pd_fault: assert property (p_pd_fault) else $error("fault flag missing");
  property p_align; alignment_bypass_o |-> scrambler_bypass_o; endproperty
  a_align: assert property (p_align) else $error("alignment bypass kept scrambler");
  property p_tx_rst; $fell(rst_i) |-> tx_mode_o; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("medium not twisted pair");
endmodule // phy_regs_monitor

bind phy_autoneg_regs phy_regs_monitor i_phy_regs_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .mgmt_addr_i(mgmt_addr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o),
  .page_valid_i(page_valid_i), .pd_fault_i(pd_fault_i), .an_restart_i(an_restart_i),
  .scrambler_bypass_o(scrambler_bypass_o),
  .alignment_bypass_o(alignment_bypass_o), .tx_mode_o(tx_mode_o));

// ---- verif/negotiation_partner.sv ----
module negotiation_partner (
  // Clock
  input wire logic core_clk_i,
  // Engine events
  output logic page_valid_o,
  output logic [15:0] page_word_o,
  output logic page_ack_o,
  output logic pd_fault_o,
  output logic an_restart_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] evt = 3'h0;
  // Ack only ever comes from the burst engine
  assign {page_ack_o, pd_fault_o, an_restart_o} = evt;
  initial begin
    page_valid_o = 1'b0;
    page_word_o = 16'h0000;
  end
  task automatic send_page(input logic [15:0] word);
    @(negedge core_clk_i);
    page_valid_o = 1'b1;
    page_word_o = word;
    @(negedge core_clk_i);
    page_valid_o = 1'b0;
    // Word no longer qualified: show its inverse, not a stale copy
    page_word_o = ~word;
  endtask
  task automatic pulse(input int n);
    @(negedge core_clk_i);
    evt[n] = 1'b1;
    @(negedge core_clk_i);
    evt = 3'h0;
  endtask
endmodule // negotiation_partner

// ---- verif/phy_autoneg_partner_and_config_regs_test.sv ----
module phy_autoneg_partner_and_config_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_regs_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] mgmt_addr_i = 5'h00;
  logic mgmt_wr_i = 1'b0;
  logic mgmt_rd_i = 1'b0;
  logic [15:0] mgmt_wdata_i = 16'h0000;
  logic [15:0] mgmt_rdata_o;
  logic mgmt_rvalid_o;
  logic page_valid_i, page_ack_i, pd_fault_i, an_restart_i;
  logic [15:0] page_word_i;
  logic repeater_strap_i = 1'b1;
  logic signal_detect_i = 1'b0;
  wire logic [6:0] outs;
  logic [15:0] cfg;
  int n_mismatch = 0;
  int comparisons = 0;
  always #10 core_clk_i = ~core_clk_i;
  negotiation_partner i_negotiation_partner (.core_clk_i(core_clk_i), .page_valid_o(page_valid_i),
    .page_word_o(page_word_i), .page_ack_o(page_ack_i), .pd_fault_o(pd_fault_i), .an_restart_o(an_restart_i));
  phy_autoneg_regs i_phy_autoneg_regs (.core_clk_i(core_clk_i), .rst_i(rst_i), .mgmt_addr_i(mgmt_addr_i),
    .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_wdata_i(mgmt_wdata_i), .mgmt_rdata_o(mgmt_rdata_o),
    .mgmt_rvalid_o(mgmt_rvalid_o), .page_valid_i(page_valid_i), .page_word_i(page_word_i), .page_ack_i(page_ack_i),
    .pd_fault_i(pd_fault_i), .an_restart_i(an_restart_i), .repeater_strap_i(repeater_strap_i),
    .signal_detect_i(signal_detect_i), .coding_bypass_o(outs[6]), .scrambler_bypass_o(outs[5]),
    .alignment_bypass_o(outs[4]), .signal_detect_o(outs[3]), .repeater_mode_o(outs[2]), .tx_mode_o(outs[1]),
    .far_end_fault_enable_o(outs[0]));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge core_clk_i);
    mgmt_addr_i = a;
    mgmt_wdata_i = d;
    mgmt_wr_i = 1'b1;
    @(negedge core_clk_i);
    mgmt_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge core_clk_i);
    mgmt_addr_i = a;
    mgmt_rd_i = 1'b1;
    @(negedge core_clk_i);
    mgmt_rd_i = 1'b0;
    check(16'(mgmt_rvalid_o), 16'h0001);
    check(mgmt_rdata_o, exp);
  endtask
  // Expected datapath controls for a config word and raw detect
  function automatic logic [15:0] ctl(input logic [15:0] c, input logic s);
    return 16'({c[15], c[14] | c[13], c[13], c[12] | s, c[11], c[10], c[9]});
  endfunction
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge core_clk_i);
    rst_i = 1'b0;
    // Controls follow the register one edge after release
    @(negedge core_clk_i);
    check(16'(outs), ctl(16'h0C00, 1'b0));
    rd(PARTNER_ABILITY_OFS, 16'h0000);
    rd(AUTONEG_EXPANSION_OFS, 16'h0000);
    rd(VENDOR_CONFIGURATION_OFS, 16'h0C00);
    wr(PARTNER_ABILITY_OFS, 16'hFFFF);
    wr(AUTONEG_EXPANSION_OFS, 16'hFFFF);
    wr(5'h03, 16'hFFFF);
    rd(PARTNER_ABILITY_OFS, 16'h0000);
    rd(AUTONEG_EXPANSION_OFS, 16'h0000);
    rd(5'h03, 16'h0000);
    i_negotiation_partner.send_page(16'hFFFF);
    rd(AUTONEG_EXPANSION_OFS, 16'h000B);
    rd(PARTNER_ABILITY_OFS, 16'hE7FF);
    rd(AUTONEG_EXPANSION_OFS, 16'h0009);
    i_negotiation_partner.send_page(16'h0421);
    i_negotiation_partner.pulse(2);
    rd(PARTNER_ABILITY_OFS, 16'h4421);
    rd(AUTONEG_EXPANSION_OFS, 16'h0003);
    i_negotiation_partner.pulse(1);
    rd(AUTONEG_EXPANSION_OFS, 16'h0011);
    rd(AUTONEG_EXPANSION_OFS, 16'h0001);
    i_negotiation_partner.pulse(0);
    rd(PARTNER_ABILITY_OFS, 16'h0000);
    rd(AUTONEG_EXPANSION_OFS, 16'h0000);
    // Walk each control bit; low bits written high must read back zero
    for (int b = 9; b < 16; b++) begin
      cfg = 16'h0001 << b;
      wr(VENDOR_CONFIGURATION_OFS, cfg | 16'h01FF);
      repeat (2) @(negedge core_clk_i);
      check(16'(outs), ctl(cfg, 1'b0));
      rd(VENDOR_CONFIGURATION_OFS, cfg);
    end
    signal_detect_i = 1'b1;
    wr(VENDOR_CONFIGURATION_OFS, 16'h0000);
    repeat (2) @(negedge core_clk_i);
    check(16'(outs), ctl(16'h0000, 1'b1));
    repeater_strap_i = 1'b0;
    rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    rd(VENDOR_CONFIGURATION_OFS, 16'h0400);
    check(16'(outs), ctl(16'h0400, 1'b1));
    test_done();
  end
endmodule // phy_autoneg_partner_and_config_regs_test
